// *** src/poh_insert_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts for H4/Z3 insertion.
// Assumes: Included by both ends; definitions only.
// Notes:   Counts are in overhead port clock periods unless named otherwise.
`ifndef POH_INSERT_PARAMS_SVH
`define POH_INSERT_PARAMS_SVH

// Device register map.
`define SRC_SELECT_OFFSET   16'h1982
`define H4_VALUE_OFFSET     16'h19a7
`define Z3_VALUE_OFFSET     16'h19ab
`define H4_INSERTED_OFFSET  16'h19f0
`define Z3_INSERTED_OFFSET  16'h19f1
`define SRC_SELECT_RESET    8'h00
`define SRC_SELECT_RW_MASK  8'h0f
`define VALUE_RESET         8'h00

// Fields of the source select register.
`define H4_SEL_BIT          0
`define Z3_SEL_BIT          1

// Serial slot timing.
`define H4_WAIT_PERIODS     40
`define Z3_WAIT_PERIODS     48
`define BYTE_BITS           8
`define FRAME_PERIODS       80
`define HALF_CYCLES         4

// Host register map.
`define HOST_CTRL_OFFSET    4'h0
`define HOST_H4_OFFSET      4'h1
`define HOST_Z3_OFFSET      4'h2
`define HOST_FRAMES_OFFSET  4'h3
`define HOST_CTRL_RESET     8'h00
`define HOST_SEND_H4_BIT    0
`define HOST_SEND_Z3_BIT    1
`define HOST_REQ_EN_BIT     2

`endif

// *** src/poh_insert_pkg.sv ***
// Purpose: Shared types for the overhead insertion link.
// Assumes: Nothing beyond the parameter header.
// Notes:   Numbers live in the header; this package holds types.
package poh_insert_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] dev_addr_t;
    typedef logic [3:0]  host_addr_t;

    // Host link state, Gray coded along idle, wait, shift.
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b00,
        LINK_WAIT  = 2'b01,
        LINK_SHIFT = 2'b11
    } link_state_t;

endpackage : poh_insert_pkg

// *** src/overhead_link_if.sv ***
// Purpose: Serial path overhead link between the framer and the external insertion logic.
// Assumes: The framer end makes the port clock.
// Notes:   No two-way pins; every wire has one driver.
`timescale 1ns/100ps
`default_nettype none

interface overhead_link_if;
    logic overhead_port_clock;
    logic overhead_slot_valid;
    logic overhead_frame_marker;
    logic overhead_serial_in;
    logic overhead_insert_request;

    // Framer side.
    modport device_end (
        output overhead_port_clock,
        output overhead_slot_valid,
        output overhead_frame_marker,
        input  overhead_serial_in,
        input  overhead_insert_request
    );

    // External insertion logic side.
    modport host_end (
        input  overhead_port_clock,
        input  overhead_slot_valid,
        input  overhead_frame_marker,
        output overhead_serial_in,
        output overhead_insert_request
    );
endinterface : overhead_link_if

`default_nettype wire

// *** src/poh_device_end.sv ***
// Purpose: Chooses the H4 and Z3 bytes of each outbound SPE from registers or the serial port.
// Assumes: Registers reached over a plain strobe port; data one cycle after the read strobe.
// Notes:   The port clock is clk divided down; all logic here runs on clk.
//
// How it works
// - H4 select set takes H4 from serial port.
// - H4 select clear inserts H4 value register unless insert request seen at first bit.
// - Z3 select clear inserts Z3 value register unless insert request seen at first bit.
// - Z3 select set takes Z3 from serial port.
// - Z3 value register, eight bits, resets zero.
// - Select register: high nibble zero, low nibble writable.
// - Far end samples valid and marker on rise.
// - Far end waits 40 periods before H4.
// - Far end waits 48 periods before Z3.
// - H4 slot follows five overhead bytes.
// - Z3 slot follows six overhead bytes.
// - Far end drives MSB on next falling edge.
// - Each serial bit latched on following rise.
// - Far end drives remaining seven bits, MSB first.
// - Far end repeats the sequence every frame.
// - Far end may leave insert request idle.
`include "poh_insert_params.svh"
`timescale 1ns/100ps
`default_nettype none

module poh_device_end #(
    parameter int HALF_CYCLES   = `HALF_CYCLES,
    parameter int FRAME_PERIODS = `FRAME_PERIODS
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire poh_insert_pkg::dev_addr_t reg_addr,
    input  wire poh_insert_pkg::byte_t  reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output var  poh_insert_pkg::byte_t  reg_rdata,
    output var  poh_insert_pkg::byte_t  h4_byte,
    output var  poh_insert_pkg::byte_t  z3_byte,
    output var  logic                   overhead_strobe,
    overhead_link_if.device_end         link
);
    import poh_insert_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Widths and slot positions.

    localparam int PW = $clog2(FRAME_PERIODS);
    localparam int DW = $clog2(2 * HALF_CYCLES);
    localparam logic [PW-1:0] LAST_PERIOD = PW'(FRAME_PERIODS - 1);
    localparam logic [PW-1:0] H4_FIRST    = PW'(`H4_WAIT_PERIODS + 1);
    localparam logic [PW-1:0] H4_LAST     = PW'(`H4_WAIT_PERIODS + `BYTE_BITS);
    localparam logic [PW-1:0] Z3_FIRST    = PW'(`Z3_WAIT_PERIODS + 1);
    localparam logic [PW-1:0] Z3_LAST     = PW'(`Z3_WAIT_PERIODS + `BYTE_BITS);
    localparam logic [DW-1:0] DIV_RISE    = DW'(HALF_CYCLES - 1);
    localparam logic [DW-1:0] DIV_LAST    = DW'(2 * HALF_CYCLES - 1);

    byte_t            sel_r;
    byte_t            h4_value_r;
    byte_t            z3_value_r;
    logic [DW-1:0]    dcnt_r;
    logic [PW-1:0]    pcnt_r;
    logic             port_clk_r;
    logic             valid_r;
    logic             marker_r;
    logic             ser_s1_r;
    logic             ser_s2_r;
    logic             req_s1_r;
    logic             req_s2_r;
    byte_t            h4_shift_r;
    byte_t            z3_shift_r;
    logic             h4_req_r;
    logic             z3_req_r;
    logic             sample;
    logic             in_h4;
    logic             in_z3;
    logic             h4_serial;
    logic             z3_serial;

    ////////////////////////////////////////////////////////////////////////
    // Register writes.

    // Only the low nibble of the select register is writable.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_r      <= `SRC_SELECT_RESET;
            h4_value_r <= `VALUE_RESET;
            z3_value_r <= `VALUE_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `SRC_SELECT_OFFSET: sel_r <= reg_wdata & `SRC_SELECT_RW_MASK;
                `H4_VALUE_OFFSET:   h4_value_r <= reg_wdata;
                `Z3_VALUE_OFFSET:   z3_value_r <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read data stands for one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SRC_SELECT_OFFSET:  reg_rdata <= sel_r;
                `H4_VALUE_OFFSET:    reg_rdata <= h4_value_r;
                `Z3_VALUE_OFFSET:    reg_rdata <= z3_value_r;
                `H4_INSERTED_OFFSET: reg_rdata <= h4_byte;
                `Z3_INSERTED_OFFSET: reg_rdata <= z3_byte;
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port clock divider and period counter.

    // One port clock period is low for HALF_CYCLES, then high for HALF_CYCLES.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dcnt_r <= '0;
        end else if (dcnt_r == DIV_LAST) begin
            dcnt_r <= '0;
        end else begin
            dcnt_r <= dcnt_r + 1'b1;
        end
    end

    // The clock rises after the low half and falls when the period wraps.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_clk_r <= 1'b0;
        end else if (dcnt_r == DIV_RISE) begin
            port_clk_r <= 1'b1;
        end else if (dcnt_r == DIV_LAST) begin
            port_clk_r <= 1'b0;
        end
    end

    // Starting at the last period makes the first wrap open a clean frame.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pcnt_r <= LAST_PERIOD;
        end else if (dcnt_r == DIV_LAST) begin
            pcnt_r <= (pcnt_r == LAST_PERIOD) ? '0 : pcnt_r + 1'b1;
        end
    end

    // Valid and marker change with the falling edge so the far end sees them settled.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            valid_r  <= 1'b0;
            marker_r <= 1'b0;
        end else if (dcnt_r == DIV_LAST) begin
            valid_r  <= 1'b1;
            marker_r <= (pcnt_r == LAST_PERIOD);
        end
    end

    assign link.overhead_port_clock   = port_clk_r;
    assign link.overhead_slot_valid   = valid_r;
    assign link.overhead_frame_marker = marker_r;

    ////////////////////////////////////////////////////////////////////////
    // Serial input capture.

    // Both link inputs come from another domain and pass two flip-flops first.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ser_s1_r <= 1'b0;
            ser_s2_r <= 1'b0;
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            ser_s1_r <= link.overhead_serial_in;
            ser_s2_r <= ser_s1_r;
            req_s1_r <= link.overhead_insert_request;
            req_s2_r <= req_s1_r;
        end
    end

    // The last clk of each high half stands for the rising edge; the bit is settled by then.
    assign sample = (dcnt_r == DIV_LAST);
    assign in_h4  = (pcnt_r >= H4_FIRST) && (pcnt_r <= H4_LAST);
    assign in_z3  = (pcnt_r >= Z3_FIRST) && (pcnt_r <= Z3_LAST);

    // Bits shift in most significant first, one per period.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            h4_shift_r <= 8'h00;
            z3_shift_r <= 8'h00;
        end else if (sample) begin
            if (in_h4) begin
                h4_shift_r <= {h4_shift_r[6:0], ser_s2_r};
            end
            if (in_z3) begin
                z3_shift_r <= {z3_shift_r[6:0], ser_s2_r};
            end
        end
    end

    // A request seen at a slot's first bit makes that byte serial for this frame.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            h4_req_r <= 1'b0;
            z3_req_r <= 1'b0;
        end else if (sample) begin
            if (pcnt_r == H4_FIRST) begin
                h4_req_r <= req_s2_r;
            end
            if (pcnt_r == Z3_FIRST) begin
                z3_req_r <= req_s2_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte source choice.

    assign h4_serial = sel_r[`H4_SEL_BIT] | h4_req_r;
    assign z3_serial = sel_r[`Z3_SEL_BIT] | z3_req_r;

    // Both bytes commit together once the Z3 slot has closed.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            h4_byte <= `VALUE_RESET;
            z3_byte <= `VALUE_RESET;
        end else if (sample && (pcnt_r == Z3_LAST)) begin
            h4_byte <= h4_serial ? h4_shift_r : h4_value_r;
            z3_byte <= z3_serial ? {z3_shift_r[6:0], ser_s2_r} : z3_value_r;
        end
    end

    // One-cycle pulse when new H4 and Z3 bytes are ready for the SPE.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            overhead_strobe <= 1'b0;
        end else begin
            overhead_strobe <= sample && (pcnt_r == Z3_LAST);
        end
    end

endmodule : poh_device_end

`default_nettype wire

// *** src/poh_host_end.sv ***
// Purpose: External insertion logic that shifts H4 and Z3 into the framer's serial port.
// Assumes: The link runs on the port clock made by the framer end.
// Notes:   Settings cross from clk to the link by a toggle handshake.
`include "poh_insert_params.svh"
`timescale 1ns/100ps
`default_nettype none

module poh_host_end (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire poh_insert_pkg::host_addr_t reg_addr,
    input  wire poh_insert_pkg::byte_t   reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output var  poh_insert_pkg::byte_t   reg_rdata,
    overhead_link_if.host_end            link
);
    import poh_insert_pkg::*;

    localparam logic [5:0] WAIT_LAST = 6'(`H4_WAIT_PERIODS - 1);
    localparam logic [5:0] SHIFT_END = 6'(`Z3_WAIT_PERIODS + `BYTE_BITS - 1);
    localparam logic [2:0] H4_SLOT   = 3'(`H4_WAIT_PERIODS / `BYTE_BITS);
    localparam logic [2:0] Z3_SLOT   = 3'(`Z3_WAIT_PERIODS / `BYTE_BITS);

    byte_t       ctrl_r, h4_r, z3_r, x_ctrl_r, x_h4_r, x_z3_r, frames_r;
    logic        dirty_r, req_tgl_r, ack_s1_r, ack_s2_r, pending, cfg_wr;
    logic        fr_s1_r, fr_s2_r, fr_s3_r;
    logic        lrst_s1_r, lrst_s2_r, rq_s1_r, rq_s2_r, rq_s3_r, ack_tgl_r;
    byte_t       l_ctrl_r, l_h4_r, l_z3_r;
    link_state_t state_r;
    logic [5:0]  cnt_r;
    logic        frame_tgl_r, ser_r, ins_r;

    ////////////////////////////////////////////////////////////////////////
    // Software side on clk.

    assign cfg_wr  = reg_wr && (reg_addr <= `HOST_Z3_OFFSET);
    assign pending = (req_tgl_r != ack_s2_r);

    // Settings registers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_r <= `HOST_CTRL_RESET;
            h4_r   <= 8'h00;
            z3_r   <= 8'h00;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `HOST_CTRL_OFFSET: ctrl_r <= reg_wdata;
                `HOST_H4_OFFSET:   h4_r   <= reg_wdata;
                `HOST_Z3_OFFSET:   z3_r   <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // A write during a pending transfer keeps the dirty flag set.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dirty_r   <= 1'b0;
            req_tgl_r <= 1'b0;
            x_ctrl_r  <= `HOST_CTRL_RESET;
            x_h4_r    <= 8'h00;
            x_z3_r    <= 8'h00;
        end else begin
            dirty_r <= cfg_wr | (dirty_r & pending);
            if (dirty_r && !pending) begin
                x_ctrl_r  <= ctrl_r;
                x_h4_r    <= h4_r;
                x_z3_r    <= z3_r;
                req_tgl_r <= ~req_tgl_r;
            end
        end
    end

    // Acknowledge and frame toggles coming back from the link.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            fr_s1_r  <= 1'b0;
            fr_s2_r  <= 1'b0;
            fr_s3_r  <= 1'b0;
            frames_r <= 8'h00;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            fr_s1_r  <= frame_tgl_r;
            fr_s2_r  <= fr_s1_r;
            fr_s3_r  <= fr_s2_r;
            if (fr_s2_r != fr_s3_r) begin
                frames_r <= frames_r + 8'h01;
            end
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `HOST_CTRL_OFFSET:   reg_rdata <= ctrl_r;
                `HOST_H4_OFFSET:     reg_rdata <= h4_r;
                `HOST_Z3_OFFSET:     reg_rdata <= z3_r;
                `HOST_FRAMES_OFFSET: reg_rdata <= frames_r;
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side on the port clock.

    // Reset, gated by slot valid so the first port clock rises see it, and the request pass two flip-flops.
    always_ff @(posedge link.overhead_port_clock) begin
        lrst_s1_r <= reset_n & link.overhead_slot_valid;
        lrst_s2_r <= lrst_s1_r;
        rq_s1_r   <= req_tgl_r;
        rq_s2_r   <= rq_s1_r;
    end

    // A changed request loads the stable transfer copy and is acknowledged.
    always_ff @(posedge link.overhead_port_clock) begin
        if (!lrst_s2_r) begin
            rq_s3_r   <= 1'b0;
            ack_tgl_r <= 1'b0;
            l_ctrl_r  <= `HOST_CTRL_RESET;
            l_h4_r    <= 8'h00;
            l_z3_r    <= 8'h00;
        end else if (rq_s2_r != rq_s3_r) begin
            rq_s3_r   <= rq_s2_r;
            ack_tgl_r <= rq_s2_r;
            l_ctrl_r  <= x_ctrl_r;
            l_h4_r    <= x_h4_r;
            l_z3_r    <= x_z3_r;
        end
    end

    // Sequencer: watch for valid with marker, wait, shift, then watch again.
    always_ff @(posedge link.overhead_port_clock) begin
        if (!lrst_s2_r) begin
            state_r     <= LINK_IDLE;
            cnt_r       <= 6'h00;
            frame_tgl_r <= 1'b0;
        end else begin
            unique case (state_r)
                LINK_IDLE: begin
                    if (link.overhead_slot_valid && link.overhead_frame_marker) begin
                        state_r     <= LINK_WAIT;
                        cnt_r       <= 6'h00;
                        frame_tgl_r <= ~frame_tgl_r;
                    end
                end
                LINK_WAIT: begin
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == WAIT_LAST) begin
                        state_r <= LINK_SHIFT;
                    end
                end
                LINK_SHIFT: begin
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == SHIFT_END) begin
                        state_r <= LINK_IDLE;
                    end
                end
                default: state_r <= LINK_IDLE;
            endcase
        end
    end

    // Bits leave on falling edges, most significant first, in each enabled slot.
    always_ff @(negedge link.overhead_port_clock) begin
        if (!lrst_s2_r || state_r != LINK_SHIFT) begin
            ser_r <= 1'b0;
            ins_r <= 1'b0;
        end else if (cnt_r[5:3] == H4_SLOT && l_ctrl_r[`HOST_SEND_H4_BIT]) begin
            ser_r <= l_h4_r[~cnt_r[2:0]];
            ins_r <= l_ctrl_r[`HOST_REQ_EN_BIT];
        end else if (cnt_r[5:3] == Z3_SLOT && l_ctrl_r[`HOST_SEND_Z3_BIT]) begin
            ser_r <= l_z3_r[~cnt_r[2:0]];
            ins_r <= l_ctrl_r[`HOST_REQ_EN_BIT];
        end else begin
            ser_r <= 1'b0;
            ins_r <= 1'b0;
        end
    end

    assign link.overhead_serial_in      = ser_r;
    assign link.overhead_insert_request = ins_r;

endmodule : poh_host_end

`default_nettype wire

// *** tb/poh_link_chk.sv ***
// Purpose: Timing checks on the overhead serial link.
// Assumes: Port clock halves last four clk cycles each.
// Notes:   The period count restarts at every frame marker.
`timescale 1ns/100ps
`default_nettype none

module poh_link_chk #(
    parameter int FRAME_PERIODS = 80
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic overhead_port_clock,
    input wire logic overhead_slot_valid,
    input wire logic overhead_frame_marker,
    input wire logic overhead_serial_in,
    input wire logic overhead_insert_request
);
    logic       pclk_r;
    logic       seen_r;
    logic [7:0] period_r;
    logic       fall;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////
    // A falling port clock opens a new period.
    assign fall = pclk_r & ~overhead_port_clock;

    // Counts periods since the last frame marker.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pclk_r   <= 1'b0;
            seen_r   <= 1'b0;
            period_r <= 8'h00;
        end else begin
            pclk_r <= overhead_port_clock;
            if (overhead_frame_marker) begin
                seen_r   <= 1'b1;
                period_r <= 8'h00;
            end else if (fall) begin
                period_r <= period_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    sequence s_high_half;
        overhead_port_clock [*4] ##1 !overhead_port_clock;
    endsequence
    sequence s_marker_period;
        overhead_frame_marker [*8] ##1 !overhead_frame_marker;
    endsequence
    property p_clock_high;
        $rose(overhead_port_clock) |-> s_high_half;
    endproperty
    a_clock_high: assert property (p_clock_high)
        else $error("Port clock high half is wrong.");
    property p_marker_width;
        $rose(overhead_frame_marker) |-> s_marker_period;
    endproperty
    a_marker_width: assert property (p_marker_width)
        else $error("Frame marker is not one period.");
    property p_marker_valid;
        overhead_frame_marker |-> overhead_slot_valid;
    endproperty
    a_marker_valid: assert property (p_marker_valid)
        else $error("Frame marker without slot valid.");
    property p_frame_spacing;
        $rose(overhead_frame_marker) && seen_r |-> period_r == 8'(FRAME_PERIODS - 1);
    endproperty
    a_frame_spacing: assert property (p_frame_spacing)
        else $error("Frame spacing is wrong.");
    property p_serial_window;
        overhead_serial_in && !fall |-> period_r >= 8'd41 && period_r <= 8'd56;
    endproperty
    a_serial_window: assert property (p_serial_window)
        else $error("Serial data outside its slot.");
    property p_serial_on_fall;
        $changed(overhead_serial_in) |-> fall;
    endproperty
    a_serial_on_fall: assert property (p_serial_on_fall)
        else $error("Serial data changed off a falling edge.");
    property p_serial_high_stable;
        $rose(overhead_port_clock) |-> $stable(overhead_serial_in) throughout overhead_port_clock [*4];
    endproperty
    a_serial_high_stable: assert property (p_serial_high_stable)
        else $error("Serial data moved while port clock high.");
    property p_request_window;
        overhead_insert_request && !fall |-> period_r >= 8'd41 && period_r <= 8'd56;
    endproperty
    a_request_window: assert property (p_request_window)
        else $error("Insert request outside a slot.");
endmodule : poh_link_chk

`default_nettype wire

// *** tb/sts3c_poh_h4_z3_insertion_tb_top.sv ***
// Purpose: Drives both ends through setup and checks the inserted bytes.
// Assumes: Device made port clock; both ends share clk and reset.
// Notes:   Each run waits two frames so settings have crossed.
`include "poh_insert_params.svh"
`timescale 1ns/100ps
`default_nettype none

module sts3c_poh_h4_z3_insertion_tb_top;
    import poh_insert_pkg::*;

    logic       clk;
    logic       reset_n;
    dev_addr_t  d_addr;
    byte_t      d_wdata;
    logic       d_wr;
    logic       d_rd;
    byte_t      d_rdata;
    byte_t      h4_byte;
    byte_t      z3_byte;
    logic       strobe;
    host_addr_t h_addr;
    byte_t      h_wdata;
    logic       h_wr;
    logic       h_rd;
    byte_t      h_rdata;
    int         fails = 0;
    int         total_checks = 0;
    int         cycles = 0;

    overhead_link_if link_if ();
    poh_device_end #(.HALF_CYCLES(4), .FRAME_PERIODS(80)) poh_device_end_inst (.clk(clk), .reset_n(reset_n),
        .reg_addr(d_addr), .reg_wdata(d_wdata), .reg_wr(d_wr), .reg_rd(d_rd), .reg_rdata(d_rdata),
        .h4_byte(h4_byte), .z3_byte(z3_byte), .overhead_strobe(strobe), .link(link_if));
    poh_host_end poh_host_end_inst (.clk(clk), .reset_n(reset_n), .reg_addr(h_addr), .reg_wdata(h_wdata),
        .reg_wr(h_wr), .reg_rd(h_rd), .reg_rdata(h_rdata), .link(link_if));
    poh_link_chk #(.FRAME_PERIODS(80)) poh_link_chk_inst (.clk(clk), .reset_n(reset_n),
        .overhead_port_clock(link_if.overhead_port_clock), .overhead_slot_valid(link_if.overhead_slot_valid),
        .overhead_frame_marker(link_if.overhead_frame_marker), .overhead_serial_in(link_if.overhead_serial_in),
        .overhead_insert_request(link_if.overhead_insert_request));

    ////////////////////////////////////////////////////////////
    // Free running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic check(input string name, input byte_t seen, input byte_t exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One strobe cycle on the chosen end, the other end idle.
    task automatic wr(input bit host, input dev_addr_t a, input byte_t d);
        @(posedge clk);
        d_addr  <= a;
        h_addr  <= a[3:0];
        d_wdata <= d;
        h_wdata <= d;
        d_wr    <= !host;
        h_wr    <= host;
        @(posedge clk);
        d_wr <= 1'b0;
        h_wr <= 1'b0;
    endtask : wr

    task automatic rd(input bit host, input dev_addr_t a, input byte_t exp, input string name);
        @(posedge clk);
        d_addr <= a;
        h_addr <= a[3:0];
        d_rd   <= !host;
        h_rd   <= host;
        @(posedge clk);
        d_rd <= 1'b0;
        h_rd <= 1'b0;
        #1;
        check(name, host ? h_rdata : d_rdata, exp);
    endtask : rd

    // Waits for k commit strobes, each within a bounded time.
    task automatic frames(input int k);
        int n;
        repeat (k) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (strobe !== 1'b1 && n < 1500);
            check("strobe", {7'h00, strobe}, 8'h01);
        end
    endtask : frames

    // Register values 5a and c3 stand beside the host's serial bytes.
    task automatic run(input byte_t sel, input byte_t ctl, input byte_t sh4, input byte_t sz3,
                       input byte_t eh4, input byte_t ez3);
        wr(0, `SRC_SELECT_OFFSET, sel);
        wr(0, `H4_VALUE_OFFSET, 8'h5a);
        wr(0, `Z3_VALUE_OFFSET, 8'hc3);
        wr(1, 16'(`HOST_CTRL_OFFSET), ctl);
        wr(1, 16'(`HOST_H4_OFFSET), sh4);
        wr(1, 16'(`HOST_Z3_OFFSET), sz3);
        frames(2);
        check("h4 byte", h4_byte, eh4);
        check("z3 byte", z3_byte, ez3);
        rd(0, `H4_INSERTED_OFFSET, eh4, "last h4");
        rd(0, `Z3_INSERTED_OFFSET, ez3, "last z3");
    endtask : run

    task automatic t_reset_values();
        rd(0, `SRC_SELECT_OFFSET, 8'h00, "select");
        rd(0, `H4_VALUE_OFFSET, 8'h00, "h4 value");
        rd(0, `Z3_VALUE_OFFSET, 8'h00, "z3 value");
        rd(1, 16'(`HOST_CTRL_OFFSET), 8'h00, "host ctrl");
        rd(1, 16'(`HOST_FRAMES_OFFSET), 8'h00, "host frames");
    endtask : t_reset_values

    task automatic t_registers();
        wr(0, `SRC_SELECT_OFFSET, 8'hff);
        rd(0, `SRC_SELECT_OFFSET, 8'h0f, "select ro bits");
        wr(0, `Z3_VALUE_OFFSET, 8'h96);
        rd(0, `Z3_VALUE_OFFSET, 8'h96, "z3 value");
        rd(0, 16'h1990, 8'h00, "unmapped");
    endtask : t_registers

    task automatic t_sources();
        run(8'h00, 8'h03, 8'h11, 8'h22, 8'h5a, 8'hc3);
        run(8'h03, 8'h03, 8'ha5, 8'h3c, 8'ha5, 8'h3c);
        run(8'h01, 8'h03, 8'h81, 8'h7e, 8'h81, 8'hc3);
        run(8'h02, 8'h03, 8'h01, 8'hfe, 8'h5a, 8'hfe);
        run(8'h00, 8'h07, 8'h69, 8'h96, 8'h69, 8'h96);
    endtask : t_sources

    task automatic t_second_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(0, `SRC_SELECT_OFFSET, 8'h00, "select after reset");
        rd(0, `Z3_VALUE_OFFSET, 8'h00, "z3 after reset");
        check("h4 after reset", h4_byte, 8'h00);
    endtask : t_second_reset

    // Main sequence.
    initial begin
        {reset_n, d_wr, d_rd, h_wr, h_rd} = 5'h00;
        d_addr  = 16'h0000;
        h_addr  = 4'h0;
        d_wdata = 8'h00;
        h_wdata = 8'h00;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_registers();
        t_sources();
        t_second_reset();
        results();
    end
endmodule : sts3c_poh_h4_z3_insertion_tb_top

`default_nettype wire
